/* hdl/amio_top.sv */
/*
 Four-axis motion I/O logic: step pulse generation, drive inhibit,
 limit and home handling with home search turnaround, and clamped
 command codes, all behind an AXI4-Lite register slave.
 Assumes one 250 MHz clock, switch inputs asynchronous to it, and a
 kill error input coming from logic on the same clock.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "amio_params.svh"
module amio_top
(
    input  wire logic                    clock,
    input  wire logic                    rst,
    input  wire amio_pkg::amio_axi_req_s axi_req,
    output      amio_pkg::amio_axi_rsp_s axi_rsp,
    input  wire logic [3:0]              fwd_limit_in,
    input  wire logic [3:0]              rev_limit_in,
    input  wire logic [3:0]              home_in,
    input  wire logic [3:0]              kill_err,
    output      amio_pkg::amio_pins_s    pins
);
    import amio_pkg::*;

    amio_state_s state_reg;
    amio_state_s state_next;

    // Byte lane merge
    function automatic logic [31:0] merge
    (
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Offset then clamp
    function automatic logic [15:0] clamp
    (
        input logic [15:0] raw,
        input logic [15:0] ofs,
        input logic [31:0] lim
    );
        logic signed [16:0] sum;
        logic signed [16:0] hi;
        logic signed [16:0] lo;
        sum = $signed({raw[15], raw}) + $signed({ofs[15], ofs});
        hi  = $signed({lim[15], lim[15:0]});
        lo  = $signed({lim[31], lim[31:16]});
        if (sum > hi)
        begin
            sum = hi;
        end
        if (sum < lo)
        begin
            sum = lo;
        end
        return sum[15:0];
    endfunction : clamp

    assign axi_rsp = state_reg.rsp;
    assign pins    = state_reg.pins;

    always_comb
    begin
        amio_state_s n;
        logic [11:0] act;
        logic [11:0] edg;
        logic [11:0] en;
        logic        wr;
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [1:0]  ax;
        logic [1:0]  ra;
        logic        dir_req;
        logic        blk;
        logic        hit_fwd;
        logic        hit_rev;
        logic        hit_home;
        logic [31:0] rd;
        logic        ok;
        amio_op_e    op;
        n = state_reg;
        act = '0;
        edg = '0;
        en = '0;
        wr = 1'b0;
        wa = 8'h00;
        wd = 32'h0000_0000;
        ax = 2'h0;
        ra = 2'h0;
        dir_req = 1'b0;
        blk = 1'b0;
        hit_fwd = 1'b0;
        hit_rev = 1'b0;
        hit_home = 1'b0;
        rd = 32'h0000_0000;
        ok = 1'b0;
        op = AMIO_MOVE;

        n.s1 = {home_in, rev_limit_in, fwd_limit_in};
        n.s2 = state_reg.s1;
        n.s3 = state_reg.s2;
        for (int i = 0; i < 12; i++)
        begin
            if (state_reg.s2[i] == state_reg.s3[i])
            begin
                n.filt[i] = state_reg.s3[i];
            end
        end

        for (int a = 0; a < 4; a++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                act[k*4+a] = state_reg.filt[k*4+a]
                    ^ state_reg.cfg[a][`AMIO_CFG_POL+k];
                en[k*4+a] = state_reg.cfg[a][`AMIO_CFG_EN+k];
            end
        end
        n.act_q = act;
        edg = act & ~state_reg.act_q & en;

        // Write address and data taken in either order
        if (axi_req.awvalid && state_reg.rsp.awready)
        begin
            n.aw_have = 1'b1;
            n.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && state_reg.rsp.wready)
        begin
            n.w_have = 1'b1;
            n.wdata = axi_req.wdata;
            n.wstrb = axi_req.wstrb;
        end
        if (state_reg.rsp.bvalid && axi_req.bready)
        begin
            n.rsp.bvalid = 1'b0;
        end
        if (state_reg.aw_have && state_reg.w_have
            && !state_reg.rsp.bvalid)
        begin
            wr = 1'b1;
            wa = {state_reg.awaddr[7:2], 2'b00};
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.rsp.bvalid = 1'b1;
            n.rsp.bresp = 2'b00;
        end
        n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
        n.rsp.wready = !n.w_have && !n.rsp.bvalid;

        ax = wa[3:2];
        if (wr)
        begin
            ok = 1'b1;
            case (wa & 8'hF0)
                `AMIO_OFS_CFG:
                begin
                    n.cfg[ax] = merge(state_reg.cfg[ax],
                        state_reg.wdata, state_reg.wstrb);
                end
                `AMIO_OFS_RAW:
                begin
                    wd = merge({16'h0000, state_reg.raw[ax]},
                        state_reg.wdata, state_reg.wstrb);
                    n.raw[ax] = wd[15:0];
                end
                `AMIO_OFS_OFFS:
                begin
                    wd = merge({16'h0000, state_reg.offs[ax]},
                        state_reg.wdata, state_reg.wstrb);
                    n.offs[ax] = wd[15:0];
                end
                `AMIO_OFS_LIM:
                begin
                    n.lim[ax] = merge(state_reg.lim[ax],
                        state_reg.wdata, state_reg.wstrb);
                end
                default:
                begin
                    ok = 1'b0;
                end
            endcase
            if (wa == `AMIO_OFS_DIV)
            begin
                wd = merge({16'h0000, state_reg.div},
                    state_reg.wdata, state_reg.wstrb);
                n.div = wd[15:0];
            end
            if (!ok && wa != `AMIO_OFS_DIV && wa != `AMIO_OFS_CMD)
            begin
                n.rsp.bresp = 2'b10;
            end
        end

        for (int a = 0; a < 4; a++)
        begin
            hit_fwd = edg[a];
            hit_rev = edg[4+a];
            hit_home = edg[8+a];
            if (state_reg.dcnt[a] != 16'h0000)
            begin
                n.dcnt[a] = state_reg.dcnt[a] - 16'h0001;
            end
            else if (state_reg.steps[a] != 16'h0000
                || state_reg.homing[a] || state_reg.pulse[a])
            begin
                n.dcnt[a] = state_reg.div;
                n.pulse[a] = !state_reg.pulse[a];
                if (state_reg.pulse[a] && !state_reg.homing[a])
                begin
                    n.steps[a] = state_reg.steps[a] - 16'h0001;
                end
            end

            if (state_reg.homing[a] && !state_reg.back[a]
                && ((hit_fwd && state_reg.fwd[a])
                || (hit_rev && !state_reg.fwd[a])))
            begin
                n.fwd[a] = !state_reg.fwd[a];
            end
            else if (state_reg.homing[a] && hit_home
                && state_reg.cfg[a][`AMIO_CFG_HSEQ]
                && !state_reg.back[a])
            begin
                n.back[a] = 1'b1;
                n.fwd[a] = !state_reg.fwd[a];
            end
            else if (state_reg.back[a] && !act[8+a])
            begin
                n.homing[a] = 1'b0;
                n.back[a] = 1'b0;
                n.pulse[a] = 1'b0;
                n.halted[a] = 1'b1;
            end
            else if (hit_fwd || hit_rev || hit_home)
            begin
                n.steps[a] = 16'h0000;
                n.homing[a] = 1'b0;
                n.back[a] = 1'b0;
                n.pulse[a] = 1'b0;
                n.dcnt[a] = 16'h0000;
                n.halted[a] = 1'b1;
            end

            if (kill_err[a])
            begin
                n.killed[a] = 1'b1;
                n.steps[a] = 16'h0000;
                n.homing[a] = 1'b0;
                n.back[a] = 1'b0;
                n.pulse[a] = 1'b0;
            end
        end

        // Motion command write
        if (wr && wa == `AMIO_OFS_CMD)
        begin
            ax = state_reg.wdata[1:0];
            op = amio_op_e'(state_reg.wdata[5:4]);
            dir_req = state_reg.wdata[`AMIO_CMD_DIR];
            blk = dir_req ? (act[ax] && en[ax])
                          : (act[4+ax] && en[4+ax]);
            case (op)
                AMIO_MOVE, AMIO_HOME:
                begin
                    // Same-cycle stop edge wins
                    if (blk || kill_err[ax] || edg[ax] || edg[4+ax]
                        || edg[8+ax])
                    begin
                        n.rej[ax] = 1'b1;
                    end
                    else
                    begin
                        n.rej[ax] = 1'b0;
                        n.halted[ax] = 1'b0;
                        n.killed[ax] = 1'b0;
                        n.fwd[ax] = dir_req;
                        n.homing[ax] = (op == AMIO_HOME);
                        n.back[ax] = 1'b0;
                        n.steps[ax] = (op == AMIO_HOME) ? 16'h0000
                            : state_reg.wdata[`AMIO_CMD_CNT +: 16];
                    end
                end
                AMIO_KILL:
                begin
                    for (int a = 0; a < 4; a++)
                    begin
                        n.killed[a] = 1'b1;
                        n.steps[a] = 16'h0000;
                        n.homing[a] = 1'b0;
                        n.back[a] = 1'b0;
                        n.pulse[a] = 1'b0;
                    end
                end
                default:
                begin
                    n.steps[ax] = 16'h0000;
                    n.homing[ax] = 1'b0;
                    n.back[ax] = 1'b0;
                    n.pulse[ax] = 1'b0;
                end
            endcase
        end

        // Pin levels, registered
        for (int a = 0; a < 4; a++)
        begin
            if (n.cfg[a][`AMIO_CFG_MODE])
            begin
                n.pins.step[a] = (n.pulse[a] && n.fwd[a])
                    ^ n.cfg[a][`AMIO_CFG_STEPINV];
                n.pins.dir[a] = (n.pulse[a] && !n.fwd[a])
                    ^ n.cfg[a][`AMIO_CFG_DIRINV];
            end
            else
            begin
                n.pins.step[a] = n.pulse[a]
                    ^ n.cfg[a][`AMIO_CFG_STEPINV];
                n.pins.dir[a] = n.fwd[a]
                    ^ n.cfg[a][`AMIO_CFG_DIRINV];
            end
            n.pins.inhibit[a] = (n.cfg[a][`AMIO_CFG_INHSET]
                || (n.cfg[a][`AMIO_CFG_AUTOINH] && n.killed[a]))
                ^ n.cfg[a][`AMIO_CFG_INHINV];
            n.pins.dac[a] = clamp(n.raw[a], n.offs[a], n.lim[a]);
        end

        // Read channel
        if (state_reg.rsp.rvalid && axi_req.rready)
        begin
            n.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && state_reg.rsp.arready)
        begin
            ra = axi_req.araddr[3:2];
            n.rsp.rresp = 2'b00;
            case ({axi_req.araddr[7:4], 4'h0})
                `AMIO_OFS_CFG:
                begin
                    rd = state_reg.cfg[ra];
                end
                `AMIO_OFS_STAT:
                begin
                    rd = {state_reg.steps[ra], 7'h00,
                        state_reg.killed[ra], state_reg.rej[ra],
                        state_reg.halted[ra], state_reg.homing[ra],
                        state_reg.fwd[ra], 1'b0, act[8+ra],
                        act[4+ra], act[ra]};
                end
                `AMIO_OFS_RAW:
                begin
                    rd = {16'h0000, state_reg.raw[ra]};
                end
                `AMIO_OFS_OFFS:
                begin
                    rd = {16'h0000, state_reg.offs[ra]};
                end
                `AMIO_OFS_LIM:
                begin
                    rd = state_reg.lim[ra];
                end
                default:
                begin
                    if ({axi_req.araddr[7:2], 2'b00} == `AMIO_OFS_DIV)
                    begin
                        rd = {16'h0000, state_reg.div};
                    end
                    else if ({axi_req.araddr[7:2], 2'b00}
                        != `AMIO_OFS_CMD)
                    begin
                        n.rsp.rresp = 2'b10;
                    end
                end
            endcase
            n.rsp.rdata = rd;
            n.rsp.rvalid = 1'b1;
        end
        n.rsp.arready = !n.rsp.rvalid;
        state_next = n;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.rsp.awready <= 1'b1;
            state_reg.rsp.wready <= 1'b1;
            state_reg.rsp.arready <= 1'b1;
            state_reg.div <= `AMIO_DIV_RST;
            for (int a = 0; a < 4; a++)
            begin
                state_reg.cfg[a] <= `AMIO_CFG_RST;
                state_reg.lim[a] <= `AMIO_LIM_RST;
            end
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule : amio_top

/* inc/amio_params.svh */
/*
 Constants of the four-axis motion I/O block: register offsets,
 field positions, reset values and the clock rate.
 Assumes inclusion by the top module only.
*/
// Contract
// - Four axes, each with step, direction, inhibit, two limits, home.
// - Each axis selects step/direction or CW/CCW mode and polarity.
// - Step/direction mode emits one step pulse per commanded step.
// - Direction output level shows forward or reverse motion.
// - CW/CCW mode pulses CW forward, CCW reverse, never both.
// - Both stepper outputs have selectable active level in both modes.
// - Inhibit output polarity is selectable per axis.
// - Kill command or kill error asserts inhibit when configured.
// - Software sets or clears each inhibit output directly.
// - Each limit and home input has its own enable.
// - Enabled active edge on limit or home halts the axis.
// - Active enabled limit rejects new motion toward it.
// - Stops are edge triggered; pulsed limits do not block.
// - Limit and home polarity programmable before edge detection.
// - Polarity-adjusted input state always readable.
// - Home search reverses at first limit and keeps searching.
// - Home edge stops, or reverses into a back-off that runs until home clears.
// - 16-bit command code clamped to range, with offset.
`ifndef AMIO_PARAMS_SVH
`define AMIO_PARAMS_SVH
`define AMIO_CLK_MHZ      250
`define AMIO_OFS_CMD      8'h00
`define AMIO_OFS_DIV      8'h04
`define AMIO_OFS_CFG      8'h10
`define AMIO_OFS_STAT     8'h20
`define AMIO_OFS_RAW      8'h30
`define AMIO_OFS_OFFS     8'h40
`define AMIO_OFS_LIM      8'h50
`define AMIO_DIV_RST      16'h0031
`define AMIO_LIM_RST      32'h8000_7FFF
`define AMIO_CFG_RST      32'h0000_0000
`define AMIO_CFG_MODE     0
`define AMIO_CFG_STEPINV  1
`define AMIO_CFG_DIRINV   2
`define AMIO_CFG_INHINV   3
`define AMIO_CFG_AUTOINH  4
`define AMIO_CFG_INHSET   5
`define AMIO_CFG_HSEQ     6
`define AMIO_CFG_EN       8
`define AMIO_CFG_POL      12
`define AMIO_CMD_DIR      8
`define AMIO_CMD_CNT      16
`endif

/* inc/amio_pkg.sv */
/*
 Types of the motion I/O block: bus carriers, pin groups, command
 codes and the full state record.
 Assumes the constants header is on the include path.
*/
package amio_pkg;
    typedef enum logic [1:0] {AMIO_MOVE, AMIO_HOME, AMIO_KILL,
        AMIO_STOP} amio_op_e;
    typedef struct packed {
        logic awvalid; logic [7:0] awaddr; logic wvalid;
        logic [31:0] wdata; logic [3:0] wstrb; logic bready;
        logic arvalid; logic [7:0] araddr; logic rready;
    } amio_axi_req_s;
    typedef struct packed {
        logic awready; logic wready; logic bvalid;
        logic [1:0] bresp; logic arready; logic rvalid;
        logic [31:0] rdata; logic [1:0] rresp;
    } amio_axi_rsp_s;
    typedef struct packed {
        logic [3:0] step; logic [3:0] dir; logic [3:0] inhibit;
        logic [3:0][15:0] dac;
    } amio_pins_s;
    typedef struct packed {
        amio_axi_rsp_s rsp;
        logic aw_have; logic w_have; logic [7:0] awaddr;
        logic [31:0] wdata; logic [3:0] wstrb;
        logic [15:0] div;
        logic [3:0][31:0] cfg; logic [3:0][31:0] lim;
        logic [3:0][15:0] raw; logic [3:0][15:0] offs;
        logic [3:0][15:0] steps; logic [3:0][15:0] dcnt;
        logic [3:0] pulse; logic [3:0] fwd; logic [3:0] homing;
        logic [3:0] back; logic [3:0] halted; logic [3:0] rej;
        logic [3:0] killed;
        logic [11:0] s1; logic [11:0] s2; logic [11:0] s3;
        logic [11:0] filt; logic [11:0] act_q;
        amio_pins_s pins;
    } amio_state_s;
endpackage : amio_pkg

/* tb/amio_assertions.sv */
/*
 Port checker for the motion I/O top: bus handshakes, pin timing.
 Assumes it is bound onto the top module; one clock domain.
*/
`timescale 1ns/1ns
module amio_assertions
    import amio_pkg::*;
(
    input wire logic                    clock,
    input wire logic                    rst,
    input wire amio_pkg::amio_axi_req_s axi_req,
    input wire amio_pkg::amio_axi_rsp_s axi_rsp,
    input wire logic [3:0]              kill_err,
    input wire amio_pkg::amio_pins_s    pins
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    bvalid_holds_a: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid) else $error("bvalid dropped early");
    rdata_holds_a: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer not held");
    write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready
        && axi_req.wvalid && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid)
        else $error("write answer late");
    read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid && !axi_rsp.arready)
        else $error("read answer late");
    bad_read_a: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr >= 8'h60
        |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    bad_write_a: assert property (axi_req.awvalid && axi_rsp.awready
        && axi_req.awaddr >= 8'h60
        |-> ##[1:3] (axi_rsp.bvalid && axi_rsp.bresp == 2'h2))
        else $error("unmapped write not refused");
    kill_stops_a: assert property (
        kill_err[0] ##1 kill_err[0] |=> !$rose(pins.step[0]))
        else $error("step after kill");
    dir_steady_a: assert property (
        pins.step[0] && $past(pins.step[0]) |-> $stable(pins.dir[0]))
        else $error("direction moved inside a step");
endmodule : amio_assertions

bind amio_top amio_assertions u_amio_assertions (.clock(clock),
    .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .kill_err(kill_err), .pins(pins));

/* tb/amio_drive_model.sv */
/*
 Stepper driver stand-in: counts rising edges on step and direction.
 Assumes the pin record of the motion I/O package.
*/
`timescale 1ns/1ns
module amio_drive_model
    import amio_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire amio_pkg::amio_pins_s pins,
    output      logic [3:0][15:0]     step_cnt,
    output      logic [3:0][15:0]     dir_cnt
);
    logic [3:0] step_q;
    logic [3:0] dir_q;

    always_ff @(posedge clock)
    begin
        step_q <= pins.step;
        dir_q  <= pins.dir;
        for (int i = 0; i < 4; i++)
        begin
            if (rst)
            begin
                step_cnt[i] <= 16'h0;
                dir_cnt[i]  <= 16'h0;
            end
            else
            begin
                step_cnt[i] <= step_cnt[i] + 16'(pins.step[i] & ~step_q[i]);
                dir_cnt[i]  <= dir_cnt[i] + 16'(pins.dir[i] & ~dir_q[i]);
            end
        end
    end
endmodule : amio_drive_model

/* tb/amio_top_bench.sv */
/*
 Register-level bench of the motion I/O top.
 Assumes the drive model counts pulses and the bench plays switches.
*/
`timescale 1ns/1ns
module amio_top_bench;
    import amio_pkg::*;
    logic             clock;
    logic             rst;
    amio_axi_req_s    req;
    amio_axi_rsp_s    rsp;
    amio_pins_s       pins;
    logic [3:0]       fwd;
    logic [3:0]       rev;
    logic [3:0]       home;
    logic [3:0]       kill;
    logic [3:0][15:0] scnt;
    logic [3:0][15:0] dcnt;
    logic [15:0]      ds;
    logic [15:0]      dd;
    logic [15:0]      b0;
    int               mismatches = 0;
    int               checks = 0;
    int               cyc = 0;
    localparam logic [31:0] raw_v [3] = '{32'h20, 32'h200, 32'hFE00};
    localparam logic [31:0] dac_v [3] = '{32'h30, 32'h100, 32'hFF00};
    localparam logic [31:0] inh_v [3] = '{32'h20, 32'h28, 32'h08};

    amio_top u_amio_top (.clock(clock), .rst(rst), .axi_req(req),
        .axi_rsp(rsp), .fwd_limit_in(fwd), .rev_limit_in(rev),
        .home_in(home), .kill_err(kill), .pins(pins));
    amio_drive_model u_amio_drive_model (.clock(clock), .rst(rst),
        .pins(pins), .step_cnt(scnt), .dir_cnt(dcnt));

    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (rsp.awready === 1'b1)
                req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1)
                req.wvalid <= 1'b0;
        end
        while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        check("bresp", 32'(rsp.bresp), a >= 8'h60 ? 32'h2 : 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge clock);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
        end
        while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        check("rresp", 32'(rsp.rresp), a >= 8'h60 ? 32'h2 : 32'h0);
        check($sformatf("reg %h", a), rsp.rdata & m, e);
    endtask : rd

    // Command, then settle, then step and direction counts
    task automatic mv(input logic [31:0] c, input int w);
        logic [15:0] s0;
        logic [15:0] d0;
        s0 = scnt[c[1:0]];
        d0 = dcnt[c[1:0]];
        wr(8'h00, c);
        repeat (w) @(posedge clock);
        ds = scnt[c[1:0]] - s0;
        dd = dcnt[c[1:0]] - d0;
    endtask : mv

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        req = '0;
        fwd = 4'h0;
        rev = 4'h0;
        home = 4'h0;
        kill = 4'h0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(8'h04, 32'h31, 32'hFFFF);
        rd(8'h50, 32'h8000_7FFF, 32'hFFFF_FFFF);
        rd(8'h60, 32'h0, 32'hFFFF_FFFF);
        wr(8'h60, 32'h1);
        wr(8'h50, 32'hFF00_0100);
        wr(8'h40, 32'h10);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h30, raw_v[i]);
            repeat (4) @(posedge clock);
            check("dac0", 32'(pins.dac[0]), dac_v[i]);
        end
        wr(8'h04, 32'h1);
        mv(32'h0003_0100, 30);
        check("steps0", 32'(ds), 32'h3);
        check("dir0", 32'(pins.dir[0]), 32'h1);
        mv(32'h0002_0000, 30);
        check("dir0", 32'(pins.dir[0]), 32'h0);
        wr(8'h14, 32'h1);
        mv(32'h0002_0001, 30);
        check("cw", 32'(ds), 32'h0);
        check("ccw", 32'(dd), 32'h2);
        mv(32'h0003_0101, 30);
        check("cw", 32'(ds), 32'h3);
        check("ccw", 32'(dd), 32'h0);
        wr(8'h18, 32'h6);
        repeat (2) @(posedge clock);
        mv(32'h0002_0102, 30);
        check("steps2", 32'(ds), 32'h2);
        check("step2", 32'(pins.step[2]), 32'h1);
        check("dir2", 32'(pins.dir[2]), 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h10, inh_v[i]);
            repeat (3) @(posedge clock);
            check("inh0", 32'(pins.inhibit[0]), 32'(i != 1));
        end
        wr(8'h10, 32'h10);
        mv(32'h0064_0100, 12);
        kill <= 4'h1;
        repeat (2) @(posedge clock);
        kill <= 4'h0;
        repeat (3) @(posedge clock);
        b0 = scnt[0];
        repeat (20) @(posedge clock);
        check("kill steps", 32'(scnt[0] - b0), 32'h0);
        check("inh0", 32'(pins.inhibit[0]), 32'h1);
        wr(8'h14, 32'h10);
        mv(32'h0064_0101, 12);
        wr(8'h00, 32'h20);
        repeat (3) @(posedge clock);
        check("inh1", 32'(pins.inhibit[1]), 32'h1);
        rd(8'h24, 32'h100, 32'h100);
        mv(32'h0001_0100, 12);
        check("inh0", 32'(pins.inhibit[0]), 32'h0);
        fwd <= 4'h1;
        repeat (8) @(posedge clock);
        rd(8'h20, 32'h1, 32'h1);
        wr(8'h10, 32'h1000);
        rd(8'h20, 32'h0, 32'h1);
        wr(8'h10, 32'h0100);
        mv(32'h0005_0100, 30);
        check("blocked", 32'(ds), 32'h0);
        rd(8'h20, 32'h80, 32'h80);
        mv(32'h0002_0000, 30);
        check("reverse", 32'(ds), 32'h2);
        fwd <= 4'h0;
        repeat (8) @(posedge clock);
        b0 = scnt[0];
        mv(32'h00C8_0100, 12);
        fwd <= 4'h1;
        repeat (6) @(posedge clock);
        fwd <= 4'h0;
        repeat (30) @(posedge clock);
        check("halt", 32'(scnt[0] - b0 < 16'h14), 32'h1);
        rd(8'h20, 32'h40, 32'h40);
        mv(32'h0002_0100, 30);
        check("unblocked", 32'(ds), 32'h2);
        mv(32'h00C8_0100, 12);
        wr(8'h00, 32'h0000_0030);
        repeat (3) @(posedge clock);
        b0 = scnt[0];
        repeat (20) @(posedge clock);
        check("stop", 32'(scnt[0] - b0), 32'h0);
        // limits and home enabled before the search
        wr(8'h14, 32'h0700);
        wr(8'h00, 32'h0000_0111);
        repeat (20) @(posedge clock);
        check("search", 32'(pins.dir[1]), 32'h1);
        fwd <= 4'h2;
        repeat (20) @(posedge clock);
        check("turn", 32'(pins.dir[1]), 32'h0);
        rd(8'h24, 32'h20, 32'h60);
        home <= 4'h2;
        repeat (20) @(posedge clock);
        rd(8'h24, 32'h40, 32'h40);
        b0 = scnt[1];
        repeat (20) @(posedge clock);
        check("home stop", 32'(scnt[1] - b0), 32'h0);
        // home input off after the search
        wr(8'h14, 32'h0300);
        fwd <= 4'h0;
        home <= 4'h0;
        repeat (8) @(posedge clock);
        wr(8'h14, 32'h0740);
        wr(8'h00, 32'h0000_0011);
        repeat (10) @(posedge clock);
        home <= 4'h2;
        repeat (10) @(posedge clock);
        rd(8'h24, 32'h30, 32'h70);
        home <= 4'h0;
        repeat (10) @(posedge clock);
        rd(8'h24, 32'h40, 32'h60);
        summarize();
    end
endmodule : amio_top_bench
